// >>> fiopb_pkg.sv
// constants, register map and lookup functions of the field i/o parameter block
// assumes an axi4-lite master with 32-bit data and one 10 MHz clock
// Contract
// R1 - stored parameters reach working copies at power-up
// R2 - stored index selects link speed from table
// R3 - stored link speed index defaults to nine
// R4 - watchdog counts milliseconds, default fifty
// R5 - working timeout zero disables the watchdog
// R6 - separate stored and working timeout values
// R7 - working timeout, output writes act at once
// R8 - host tools use setup mode or slow speed
// R9 - host enters setup mode before firmware update
// R10 - three host-selected process data modes
// R11 - mode zero carries inputs and outputs only
// R12 - mode one adds four analog readings
// R13 - mode two adds supply voltage, two encoders
// R14 - encoders count once per quadrature cycle
// R15 - timeout sets fault and forces outputs off
// R16 - fault blocks output writes, set at startup
// R17 - analog readings are 8-bit, 36.3 V full scale
// R18 - every host access restarts the watchdog count
package fiopb_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STORED_SPEED = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WORK_SPEED = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STORED_TIMEOUT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_WORK_TIMEOUT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INPUT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FAULT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FAULT_MASK = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PD_MODE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ANALOG = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_FIELD_VOLT = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_ENCODER = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_LINK_BAUD = 8'h30;
  // fault bits
  localparam int FLT_W = 2;
  localparam int FLT_WATCHDOG = 0;
  localparam int FLT_STARTUP = 1;
  localparam logic [FLT_W-1:0] FAULT_RST = 2'h2;
  localparam logic [FLT_W-1:0] MASK_RST = 2'h0;
  // link speed
  localparam int SPEED_W = 4;
  localparam logic [SPEED_W-1:0] SPEED_RST = 4'h9;
  localparam logic [SPEED_W-1:0] SPEED_MAX = 4'hb;
  localparam int BAUD_W = 24;
  // watchdog timing
  localparam int TMO_W = 16;
  localparam logic [TMO_W-1:0] TIMEOUT_RST_MS = 16'h0032;
  localparam int CLK_HZ = 10000000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  // process data
  localparam int OUT_W = 16;
  localparam int IN_W = 32;
  localparam int ANA_W = 8;
  localparam int ANA_CH = 4;
  localparam int ENC_W = 16;
  localparam int ENC_A0 = 16;
  localparam int ENC_B0 = 17;
  localparam int ENC_A1 = 18;
  localparam int ENC_B1 = 19;
  localparam logic [7:0] PD_BYTES_IO = 8'h04;
  localparam logic [7:0] PD_BYTES_ANA = 8'h08;
  localparam logic [7:0] PD_BYTES_ENC = 8'h0d;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FIOPB_MODE_IO = 2'b00,
    FIOPB_MODE_ANA = 2'b01,
    FIOPB_MODE_ENC = 2'b10
  } fiopb_mode_t;

  // speed index to baud; out-of-range indexes never get stored
  function automatic logic [BAUD_W-1:0] baud_of(input logic [SPEED_W-1:0] idx);
    case (idx)
      4'h0: baud_of = 24'h002580;
      4'h1: baud_of = 24'h004b00;
      4'h2: baud_of = 24'h009600;
      4'h3: baud_of = 24'h00e100;
      4'h4: baud_of = 24'h01c200;
      4'h5: baud_of = 24'h038400;
      4'h6: baud_of = 24'h070800;
      4'h7: baud_of = 24'h0e1000;
      4'h8: baud_of = 24'h1312d0;
      4'h9: baud_of = 24'h2625a0;
      4'ha: baud_of = 24'h4c4b40;
      4'hb: baud_of = 24'h989680;
      default: baud_of = 24'h000000;
    endcase
  endfunction

  // bytes sent toward the host per exchange
  function automatic logic [7:0] pd_bytes(input fiopb_mode_t m);
    case (m)
      FIOPB_MODE_IO: pd_bytes = PD_BYTES_IO;
      FIOPB_MODE_ANA: pd_bytes = PD_BYTES_ANA;
      FIOPB_MODE_ENC: pd_bytes = PD_BYTES_ENC;
      default: pd_bytes = PD_BYTES_IO;
    endcase
  endfunction

  // byte-lane merge for axi writes
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge_strb[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction
endpackage

// >>> fiopb_quad_enc.sv
// 1x quadrature counter for one hand wheel encoder
// assumes a and b are already synchronised to aclk
`timescale 1ns/100ps
module fiopb_quad_enc
  import fiopb_pkg::*;
#(
  parameter int CNT_W = ENC_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic en,
  input wire logic a,
  input wire logic b,
  output logic [CNT_W-1:0] count
);
  logic a_d_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  wire a_rise = a & ~a_d_r;

  // one step per full cycle: only the rising edge of a counts, b gives direction
  assign cnt_nxt = !en ? cnt_r : !a_rise ? cnt_r : b ? cnt_r - 1'b1 : cnt_r + 1'b1; // [R14]
  assign count = cnt_r;

  // edge memory and counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_d_r <= 1'b0;
      cnt_r <= '0;
    end else if (ce) begin
      a_d_r <= a;
      cnt_r <= cnt_nxt;
    end
  end

  AST_ENC_ONE_STEP: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    (ce && en && a_rise && !b) |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("encoder did not step up on a rising edge");
endmodule

// >>> fiopb_top.sv
// field i/o parameter block: stored/working parameters, watchdog, fault,
// process data selection, axi4-lite register slave
// assumes field_in comes from pins; adc and power_cycle come from aclk logic
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module fiopb_top
  import fiopb_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic power_cycle,
  input wire logic [IN_W-1:0] field_in,
  input wire logic [ANA_W*ANA_CH-1:0] adc_in,
  input wire logic [ANA_W-1:0] adc_field_volt,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [OUT_W-1:0] field_out,
  output logic [SPEED_W-1:0] link_speed_index,
  output logic [BAUD_W-1:0] link_baud,
  output logic [7:0] pd_in_bytes,
  output logic irq
);
  // axi state
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r, awready_r, wready_r, arready_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  // parameters and state
  logic [SPEED_W-1:0] stored_link_speed_index_r, work_speed_r;
  logic [TMO_W-1:0] stored_timeout_ms_r, working_timeout_ms_r;
  logic [OUT_W-1:0] out_r, field_out_r;
  logic [FLT_W-1:0] fault_r, mask_r;
  fiopb_mode_t mode_r;
  logic [ANA_W*ANA_CH-1:0] ana_r;
  logic [ANA_W-1:0] volt_r;
  logic irq_r;
  logic [BAUD_W-1:0] baud_r;
  logic [7:0] pd_bytes_r;
  logic [31:0] ms_div_r;
  logic [TMO_W-1:0] wd_cnt_r;
  logic [IN_W-1:0] in_s1_r, in_s2_r, in_s3_r, in_q_r;
  logic [ENC_W-1:0] enc0_cnt, enc1_cnt;

  // write channel decode: both halves held and no response pending
  wire wr_go = aw_full_r & w_full_r & ~bvalid_r;
  wire rd_go = s_axi_arvalid & ~rvalid_r;
  wire host_access = wr_go | rd_go;
  wire [31:0] wmerged = merge_strb(32'h00000000, wdata_r, wstrb_r);
  wire wr_stored_speed = wr_go && aw_addr_r == OFS_STORED_SPEED;
  wire wr_stored_tmo = wr_go && aw_addr_r == OFS_STORED_TIMEOUT;
  wire wr_work_tmo = wr_go && aw_addr_r == OFS_WORK_TIMEOUT;
  wire wr_output = wr_go && aw_addr_r == OFS_OUTPUT;
  wire wr_fault = wr_go && aw_addr_r == OFS_FAULT;
  wire wr_mask = wr_go && aw_addr_r == OFS_FAULT_MASK;
  wire wr_mode = wr_go && aw_addr_r == OFS_PD_MODE;
  wire wr_ro = wr_go && (aw_addr_r == OFS_WORK_SPEED || aw_addr_r == OFS_INPUT ||
    aw_addr_r == OFS_ANALOG || aw_addr_r == OFS_FIELD_VOLT || aw_addr_r == OFS_ENCODER ||
    aw_addr_r == OFS_LINK_BAUD);
  wire wr_hit = wr_stored_speed | wr_stored_tmo | wr_work_tmo | wr_output | wr_fault |
    wr_mask | wr_mode | wr_ro;

  // next values of the parameter registers
  wire [SPEED_W-1:0] wspeed = wmerged[SPEED_W-1:0];
  wire speed_ok = wspeed <= SPEED_MAX && wmerged[31:SPEED_W] == '0;
  // byte-lane merges of the write word into each register's current value
  wire [31:0] speed_merged =
    merge_strb({28'h0000000, stored_link_speed_index_r}, wdata_r, wstrb_r);
  wire [31:0] stmo_merged = merge_strb({16'h0000, stored_timeout_ms_r}, wdata_r, wstrb_r);
  wire [31:0] wtmo_merged = merge_strb({16'h0000, working_timeout_ms_r}, wdata_r, wstrb_r);
  wire [31:0] out_merged = merge_strb({16'h0000, out_r}, wdata_r, wstrb_r);
  wire [SPEED_W-1:0] stored_speed_nxt = (wr_stored_speed && speed_ok) ?
    speed_merged[SPEED_W-1:0] : stored_link_speed_index_r;
  wire [TMO_W-1:0] stored_tmo_nxt = wr_stored_tmo ? stmo_merged[TMO_W-1:0] :
    stored_timeout_ms_r;
  // a power cycle copies stored into working; stored writes never touch working
  wire [SPEED_W-1:0] work_speed_nxt = power_cycle ? stored_link_speed_index_r :
    work_speed_r; // [R1] [R2]
  wire [TMO_W-1:0] work_tmo_nxt = power_cycle ? stored_timeout_ms_r : wr_work_tmo ?
    wtmo_merged[TMO_W-1:0] : working_timeout_ms_r; // [R1] [R6] [R7]

  // watchdog: millisecond tick, down count, reload on every host access
  wire ms_tick = ms_div_r == 32'(CYC_MS - 1); // [R4]
  wire wd_on = working_timeout_ms_r != '0; // [R5]
  wire wd_expire = wd_on && ms_tick && !host_access && wd_cnt_r == 16'h0001; // [R15]
  wire [TMO_W-1:0] wd_cnt_nxt = (host_access || power_cycle) ? work_tmo_nxt : // [R18]
    (!wd_on || wd_cnt_r == '0) ? wd_cnt_r : ms_tick ? wd_cnt_r - 1'b1 : wd_cnt_r;

  // fault flags: hardware set beats a one-to-clear in the same cycle
  wire [FLT_W-1:0] flt_set = {power_cycle, wd_expire}; // [R15] [R16]
  wire [FLT_W-1:0] flt_clr = wr_fault ? wmerged[FLT_W-1:0] : '0;
  wire [FLT_W-1:0] fault_nxt = (fault_r & ~flt_clr) | flt_set; // [R16]
  wire [FLT_W-1:0] mask_nxt = wr_mask ? wmerged[FLT_W-1:0] : mask_r;
  wire fault_any = |fault_r;

  // output word: written at once when no fault, ignored while a fault stands
  wire [OUT_W-1:0] out_nxt = power_cycle ? '0 : (wr_output && !fault_any) ?
    out_merged[OUT_W-1:0] : out_r; // [R7] [R16]
  wire [OUT_W-1:0] field_out_nxt = (|fault_nxt) ? '0 : out_nxt; // [R15]

  // process data mode: only the three defined codes in bits 1:0 are accepted; the upper bits are ignored
  wire mode_ok = wmerged[1:0] == FIOPB_MODE_IO || wmerged[1:0] == FIOPB_MODE_ANA ||
    wmerged[1:0] == FIOPB_MODE_ENC;
  wire fiopb_mode_t mode_nxt = (wr_mode && mode_ok) ? fiopb_mode_t'(wmerged[1:0]) : mode_r; // [R10]
  wire ana_on = mode_r != FIOPB_MODE_IO;
  wire enc_on = mode_r == FIOPB_MODE_ENC;
  // analog readings pass as raw 8-bit codes, 36.3 V at code ff
  wire [ANA_W*ANA_CH-1:0] ana_nxt = ana_on ? adc_in : '0; // [R11] [R12] [R17]
  wire [ANA_W-1:0] volt_nxt = enc_on ? adc_field_volt : '0; // [R13]
  wire irq_nxt = |(fault_nxt & mask_nxt);

  // read data selection
  wire [ADDR_W-1:0] ra = s_axi_araddr;
  wire rd_hit = ra == OFS_STORED_SPEED || ra == OFS_WORK_SPEED || ra == OFS_STORED_TIMEOUT ||
    ra == OFS_WORK_TIMEOUT || ra == OFS_OUTPUT || ra == OFS_INPUT || ra == OFS_FAULT ||
    ra == OFS_FAULT_MASK || ra == OFS_PD_MODE || ra == OFS_ANALOG || ra == OFS_FIELD_VOLT ||
    ra == OFS_ENCODER || ra == OFS_LINK_BAUD;
  wire [31:0] rd_word =
    ra == OFS_STORED_SPEED ? {28'h0000000, stored_link_speed_index_r} :
    ra == OFS_WORK_SPEED ? {28'h0000000, work_speed_r} :
    ra == OFS_STORED_TIMEOUT ? {16'h0000, stored_timeout_ms_r} :
    ra == OFS_WORK_TIMEOUT ? {16'h0000, working_timeout_ms_r} :
    ra == OFS_OUTPUT ? {16'h0000, out_r} :
    ra == OFS_INPUT ? in_q_r :
    ra == OFS_FAULT ? {30'h00000000, fault_r} :
    ra == OFS_FAULT_MASK ? {30'h00000000, mask_r} :
    ra == OFS_PD_MODE ? {30'h00000000, mode_r} :
    ra == OFS_ANALOG ? ana_r :
    ra == OFS_FIELD_VOLT ? {24'h000000, volt_r} :
    ra == OFS_ENCODER ? {enc1_cnt, enc0_cnt} :
    ra == OFS_LINK_BAUD ? {8'h00, baud_r} : 32'h00000000;

  // axi write address/data capture, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // axi responses: write one cycle after both halves, read one cycle after arvalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_r <= rd_word;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ready outputs come from flops that track the empty state of each holding slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
    end else if (ce) begin
      awready_r <= aw_full_r ? wr_go : !s_axi_awvalid;
      wready_r <= w_full_r ? wr_go : !s_axi_wvalid;
      arready_r <= rvalid_r ? s_axi_rready : !s_axi_arvalid;
    end
  end

  // parameter registers with documented defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stored_link_speed_index_r <= SPEED_RST; // [R3]
      work_speed_r <= SPEED_RST; // [R1]
      stored_timeout_ms_r <= TIMEOUT_RST_MS; // [R4]
      working_timeout_ms_r <= TIMEOUT_RST_MS;
      mode_r <= FIOPB_MODE_IO;
      mask_r <= MASK_RST;
    end else if (ce) begin
      stored_link_speed_index_r <= stored_speed_nxt;
      work_speed_r <= work_speed_nxt;
      stored_timeout_ms_r <= stored_tmo_nxt;
      working_timeout_ms_r <= work_tmo_nxt;
      mode_r <= mode_nxt;
      mask_r <= mask_nxt;
    end
  end

  // watchdog, fault and output state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_div_r <= '0;
      wd_cnt_r <= TIMEOUT_RST_MS;
      fault_r <= FAULT_RST; // [R16]
      out_r <= '0;
      field_out_r <= '0;
    end else if (ce) begin
      ms_div_r <= ms_tick ? 32'h00000000 : ms_div_r + 1'b1;
      wd_cnt_r <= wd_cnt_nxt;
      fault_r <= fault_nxt;
      out_r <= out_nxt;
      field_out_r <= field_out_nxt;
    end
  end

  // field inputs: three stages, a bit moves once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
      in_s3_r <= '0;
      in_q_r <= '0;
    end else if (ce) begin
      in_s1_r <= field_in;
      in_s2_r <= in_s1_r;
      in_s3_r <= in_s2_r;
      in_q_r <= (in_s2_r & in_s3_r) | (in_q_r & (in_s2_r ^ in_s3_r));
    end
  end

  // process data snapshot and derived outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ana_r <= '0;
      volt_r <= '0;
      irq_r <= 1'b0;
      baud_r <= baud_of(SPEED_RST);
      pd_bytes_r <= PD_BYTES_IO;
    end else if (ce) begin
      ana_r <= ana_nxt;
      volt_r <= volt_nxt;
      irq_r <= irq_nxt;
      baud_r <= baud_of(work_speed_nxt); // [R2]
      pd_bytes_r <= pd_bytes(mode_nxt); // [R10] [R11] [R12] [R13]
    end
  end

  // two hand wheel encoders on field inputs 16..19, live only in mode two
  fiopb_quad_enc #(.CNT_W(ENC_W)) u_enc0 (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .en(enc_on), // [R13]
    .a(in_q_r[ENC_A0]), .b(in_q_r[ENC_B0]), .count(enc0_cnt)
  );
  fiopb_quad_enc #(.CNT_W(ENC_W)) u_enc1 (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .en(enc_on),
    .a(in_q_r[ENC_A1]), .b(in_q_r[ENC_B1]), .count(enc1_cnt)
  );

  // port drive
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign field_out = field_out_r;
  assign link_speed_index = work_speed_r;
  assign link_baud = baud_r;
  assign pd_in_bytes = pd_bytes_r;
  assign irq = irq_r;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_FAULT_OUT_OFF: assert property (fault_any |-> field_out_r == '0) // [R15]
    else $error("field outputs on while a fault stands");
  AST_OUT_WRITE_IGNORED: assert property ((wr_output && fault_any && !power_cycle) |=> // [R16]
    $stable(out_r))
    else $error("output word changed under a fault");
  AST_WD_DISABLED: assert property ((ce && working_timeout_ms_r == '0 && // [R5]
    !fault_r[FLT_WATCHDOG]) |=> !fault_r[FLT_WATCHDOG])
    else $error("watchdog fired while disabled");
  AST_TIMEOUT_FAULT: assert property ((ce && wd_expire) |=> fault_r[FLT_WATCHDOG] && // [R15]
    field_out_r == '0)
    else $error("timeout did not raise fault");
  AST_STORED_NO_EFFECT: assert property ((ce && wr_stored_speed && !power_cycle) |=> // [R1]
    $stable(work_speed_r) && $stable(link_baud))
    else $error("stored speed write reached working speed");
  AST_WORK_WR_KEEPS_STORED: assert property ((ce && wr_work_tmo) |=> // [R7]
    $stable(stored_timeout_ms_r))
    else $error("working timeout write changed stored value");
  AST_ACCESS_RELOAD: assert property ((ce && host_access) |=> // [R18]
    wd_cnt_r == working_timeout_ms_r)
    else $error("host access did not restart the watchdog");
  AST_MODE0_NO_ANALOG: assert property ((mode_r == FIOPB_MODE_IO && // [R11]
    $past(mode_r) == FIOPB_MODE_IO) |-> ana_r == '0 && volt_r == '0)
    else $error("analog data present in mode zero");
  AST_PD_LEN: assert property (pd_bytes_r == pd_bytes(mode_r)) // [R10]
    else $error("exchange length does not match mode");
  AST_IRQ_LEVEL: assert property (irq_r == |(fault_r & mask_r))
    else $error("interrupt does not follow masked faults");
  AST_READY_MIRROR: assert property (s_axi_awready == !aw_full_r &&
    s_axi_wready == !w_full_r && s_axi_arready == !rvalid_r)
    else $error("ready flops disagree with slot state");
  AST_POWER_CYCLE_COPY: assert property ((ce && power_cycle) |=> // [R1]
    work_speed_r == $past(stored_link_speed_index_r) && fault_r[FLT_STARTUP])
    else $error("power cycle did not copy stored parameters");

  COV_TIMEOUT: cover property (ce && wd_expire);
  COV_FAULT_CLEARED: cover property (fault_any ##1 !fault_any);
  COV_MODE_ENC: cover property (mode_r == FIOPB_MODE_ENC && enc0_cnt != '0);
  COV_SET_CLEAR_CLASH: cover property (wr_fault && wd_expire);
endmodule

// >>> fiopb_host.sv
// axi4-lite master standing in for the host link engine on the register bus
// assumes one clock; every wait ends only when the slave answers or the bench times out
`timescale 1ns/100ps
module fiopb_host
  import fiopb_pkg::*;
(
  input wire logic aclk,
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // idle bus; parameter traffic only, never a firmware update
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // one write: address and data offered together, each dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  // one read: rready held until the data word arrives
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule

// >>> fiopb_top_test.sv
// self-checking bench of the field i/o parameter block
// assumes the host model drives the register bus; ms tick shortened to 10 clocks
`timescale 1ns/100ps
module fiopb_top_test
  import fiopb_pkg::*;
;
  logic aclk, aresetn, ce, power_cycle, irq;
  logic [IN_W-1:0] field_in;
  logic [31:0] adc_in, wdata, rdata, data;
  logic [7:0] adc_field_volt, awaddr, araddr, pd_in_bytes;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [OUT_W-1:0] field_out;
  logic [SPEED_W-1:0] link_speed_index;
  logic [BAUD_W-1:0] link_baud;
  int miscompares, compares, cycles;
  logic [23:0] bauds [12] = '{24'h002580, 24'h004b00, 24'h009600, 24'h00e100, 24'h01c200,
    24'h038400, 24'h070800, 24'h0e1000, 24'h1312d0, 24'h2625a0, 24'h4c4b40, 24'h989680};
  logic [7:0] pdb [3] = '{PD_BYTES_IO, PD_BYTES_ANA, PD_BYTES_ENC};
  logic [3:0] steps [4] = '{4'h9, 4'hf, 4'h6, 4'h0};

  // design and host model
  fiopb_top #(.CYC_MS(10)) dut (.aclk, .aresetn, .ce, .power_cycle, .field_in, .adc_in,
    .adc_field_volt, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .field_out, .link_speed_index, .link_baud, .pd_in_bytes, .irq);
  fiopb_host host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  // 10 MHz clock
  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.wr(a, d, resp);
    chk("bresp", 32'(resp), 32'(RESP_OKAY));
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    host.rd(a, data, resp);
    chk("rresp", 32'(resp), 32'(RESP_OKAY));
    chk(n, data, e);
  endtask
  task automatic pcycle;
    @(posedge aclk);
    power_cycle <= 1'b1;
    @(posedge aclk);
    power_cycle <= 1'b0;
    cyc(3);
  endtask

  task automatic t_reset;
    chk("speed_idx", 32'(link_speed_index), 32'h9);
    chk("baud", 32'(link_baud), 32'h2625a0);
    rdc("stored_tmo", OFS_STORED_TIMEOUT, 32'h32);
    rdc("work_tmo", OFS_WORK_TIMEOUT, 32'h32);
    rdc("fault", OFS_FAULT, 32'h2);
    chk("irq", 32'(irq), 32'h0);
    chk("field_out", 32'(field_out), 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_speed;
    for (int i = 0; i < 12; i++) begin
      wr(OFS_STORED_SPEED, 32'(i));
      chk("speed_idx", 32'(link_speed_index), (i == 0) ? 32'h9 : 32'(i - 1));
      pcycle;
      chk("speed_idx", 32'(link_speed_index), 32'(i));
      chk("baud", 32'(link_baud), 32'(bauds[i]));
    end
    wr(OFS_STORED_SPEED, 32'h9);
    pcycle;
    wr(OFS_STORED_SPEED, 32'hc);
    pcycle;
    chk("speed_idx", 32'(link_speed_index), 32'h9);
    $display("t_speed done");
  endtask
  task automatic t_fault;
    wr(OFS_OUTPUT, 32'h1234);
    cyc(2);
    chk("field_out", 32'(field_out), 32'h0);
    rdc("output", OFS_OUTPUT, 32'h0);
    wr(OFS_FAULT, 32'h3);
    rdc("fault", OFS_FAULT, 32'h0);
    wr(OFS_OUTPUT, 32'h5a3c);
    cyc(2);
    chk("field_out", 32'(field_out), 32'h5a3c);
    $display("t_fault done");
  endtask
  task automatic t_wdog;
    wr(OFS_WORK_TIMEOUT, 32'h2);
    wr(OFS_STORED_TIMEOUT, 32'h7);
    rdc("stored_tmo", OFS_STORED_TIMEOUT, 32'h7);
    rdc("work_tmo", OFS_WORK_TIMEOUT, 32'h2);
    repeat (6) begin
      cyc(4);
      rdc("fault", OFS_FAULT, 32'h0);
    end
    chk("field_out", 32'(field_out), 32'h5a3c);
    wr(OFS_FAULT_MASK, 32'h1);
    cyc(25);
    chk("field_out", 32'(field_out), 32'h0);
    chk("irq", 32'(irq), 32'h1);
    rdc("fault", OFS_FAULT, 32'h1);
    wr(OFS_WORK_TIMEOUT, 32'h0);
    wr(OFS_FAULT, 32'h1);
    cyc(2);
    chk("irq", 32'(irq), 32'h0);
    wr(OFS_OUTPUT, 32'h00ff);
    cyc(100);
    chk("field_out", 32'(field_out), 32'h00ff);
    rdc("fault", OFS_FAULT, 32'h0);
    pcycle;
    rdc("work_tmo", OFS_WORK_TIMEOUT, 32'h7);
    chk("field_out", 32'(field_out), 32'h0);
    $display("t_wdog done");
  endtask
  task automatic t_modes;
    @(posedge aclk);
    adc_in <= 32'hff804001;
    adc_field_volt <= 8'h9c;
    for (int m = 0; m < 3; m++) begin
      wr(OFS_PD_MODE, 32'(m));
      cyc(2);
      chk("pd_bytes", 32'(pd_in_bytes), 32'(pdb[m]));
      rdc("analog", OFS_ANALOG, (m == 0) ? 32'h0 : 32'hff804001);
      rdc("field_volt", OFS_FIELD_VOLT, (m == 2) ? 32'h9c : 32'h0);
    end
    wr(OFS_PD_MODE, 32'h3);
    rdc("mode", OFS_PD_MODE, 32'h2);
    host.rd(8'h40, data, resp);
    chk("unmapped_resp", 32'(resp), 32'(RESP_SLVERR));
    chk("unmapped_data", data, 32'h0);
    $display("t_modes done");
  endtask
  // clock enable low must freeze the watchdog, so outputs survive a long pause
  task automatic t_hold;
    wr(OFS_FAULT, 32'h3);
    wr(OFS_OUTPUT, 32'h0f0f);
    ce <= 1'b0;
    cyc(200);
    ce <= 1'b1;
    chk("field_out", 32'(field_out), 32'h0f0f);
    rdc("fault", OFS_FAULT, 32'h0);
    $display("t_hold done");
  endtask
  task automatic t_enc;
    @(posedge aclk);
    field_in <= 32'h80000001;
    cyc(6);
    rdc("input", OFS_INPUT, 32'h80000001);
    repeat (4) begin
      for (int s = 0; s < 4; s++) begin
        field_in <= {12'h800, steps[s], 16'h0001};
        cyc(6);
      end
    end
    rdc("encoders", OFS_ENCODER, 32'hfffc0004);
    $display("t_enc done");
  endtask

  // hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict;
    end
  end

  // main sequence
  initial begin
    aresetn = 1'b0;
    power_cycle = 1'b0;
    ce = 1'b1;
    field_in = '0;
    adc_in = '0;
    adc_field_volt = '0;
    cyc(20);
    aresetn <= 1'b1;
    cyc(2);
    t_reset;
    t_speed;
    t_fault;
    t_wdog;
    t_modes;
    t_hold;
    t_enc;
    print_verdict;
  end
endmodule
